// file: shared/dhgt_pkg.sv
// dhgt_pkg: register map, field positions, reset values and timing constants for the timer
package dhgt_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int HALF_W = 16;
	localparam int PRE_W = 8;

	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_WIDTH_CFG = 8'h00;
	localparam logic [7:0] OFF_A_MODE = 8'h04;
	localparam logic [7:0] OFF_B_MODE = 8'h08;
	localparam logic [7:0] OFF_CONTROL = 8'h0C;
	localparam logic [7:0] OFF_FLAG_MASK = 8'h18;
	localparam logic [7:0] OFF_RAW_FLAG = 8'h1C;
	localparam logic [7:0] OFF_MASKED_FLAG = 8'h20;
	localparam logic [7:0] OFF_FLAG_CLEAR = 8'h24;
	localparam logic [7:0] OFF_A_LOAD = 8'h28;
	localparam logic [7:0] OFF_B_LOAD = 8'h2C;
	localparam logic [7:0] OFF_A_MATCH = 8'h30;
	localparam logic [7:0] OFF_A_PRESCALE = 8'h38;
	localparam logic [7:0] OFF_B_PRESCALE = 8'h3C;
	localparam logic [7:0] OFF_A_COUNT = 8'h48;
	localparam logic [7:0] OFF_B_COUNT = 8'h4C;

	// ------------------------------------------------------------
	// width configuration and half mode encodings
	// ------------------------------------------------------------
	localparam logic [2:0] CFG_TIMER32 = 3'h0;
	localparam logic [2:0] CFG_CLOCK32 = 3'h1;
	localparam logic [2:0] CFG_HALF16 = 3'h4;
	localparam logic [1:0] MODE_ONE_SHOT = 2'h1;
	localparam logic [1:0] MODE_PERIODIC = 2'h2;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTL_A_EN = 0;
	localparam int CTL_A_FREEZE = 1;
	localparam int CTL_CLOCK_RUN = 4;
	localparam int CTL_A_ADC = 5;
	localparam int CTL_B_EN = 8;
	localparam int CTL_B_FREEZE = 9;
	localparam int CTL_B_ADC = 13;
	localparam int FLG_A_TIMEOUT = 0;
	localparam int FLG_CLOCK_MATCH = 3;
	localparam int FLG_B_TIMEOUT = 8;
	localparam logic [31:0] FLAG_BITS_MASK = 32'h0000_0109;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [15:0] HALF_RESET = 16'hFFFF;
	localparam logic [7:0] PRE_RESET = 8'h00;
	localparam logic [31:0] CLOCK_START = 32'h0000_0001;
	localparam logic [31:0] CLOCK_ROLL = 32'h0000_0000;

	// ------------------------------------------------------------
	// timing: clock-mode input rate divided to a one hertz tick
	// ------------------------------------------------------------
	localparam int CLOCK_IN_HZ = 32768;
	localparam int CLOCK_TICK_HZ = 1;
	localparam int CLOCK_DIV = CLOCK_IN_HZ / CLOCK_TICK_HZ;

	typedef struct packed {
		logic b_adc;
		logic b_freeze;
		logic b_en;
		logic a_adc;
		logic clock_run;
		logic a_freeze;
		logic a_en;
	} dhgt_ctl_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} dhgt_bus_type;
endpackage

// file: logic/dhgt_timer.sv
// dhgt_timer: dual sixteen-bit timer halves with 32-bit timer and seconds-clock modes
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps

// What this block does
// - reset leaves unit idle, control cleared, counts and load registers all ones.
// - reset clears both prescale counters and prescale registers.
// - config 0 selects 32-bit timer, config 1 selects 32-bit seconds clock.
// - config 4 selects two independent 16-bit halves.
// - in 32-bit modes a half A load write fills both load registers.
// - in 32-bit modes half A count read returns B count above A count.
// - 32-bit timer is one down-counter; one-shot or periodic from half A mode.
// - 32-bit counter reloads after zero; one-shot then clears enable, periodic continues.
// - reaching zero sets raw timeout flag until cleared; mask also sets masked flag.
// - ADC trigger pulses on timeout only with that half's trigger enable.
// - load rewrite while running loads the counter on the next clock.
// - freeze bit holds the count while the processor is debug halted.
// - clock mode counts up, starting at one when first selected.
// - outside source drives 32768 Hz on capture pin, divided to one hertz.
// - clock count equal to match rolls over to zero and keeps counting.
// - clock match sets raw flag, masked flag when unmasked; clear bit clears both.
// - clock run bit keeps the clock counting during debug halt despite freeze bits.
// - 16-bit halves count down with optional 8-bit prescaler, own mode field.
// - 16-bit half reloads load and prescale after zero; one-shot clears enable.
// - 16-bit zero sets that half's raw flag, masked flag when unmasked.
// - prescale value p makes the count drop once every p+1 clocks.
module dhgt_timer #(
	parameter int CLOCK_DIV = dhgt_pkg::CLOCK_DIV
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire dhgt_pkg::dhgt_bus_type bus_i,
	output logic [dhgt_pkg::DATA_W-1:0] rdata_o,
	input wire logic dbg_halt_i,
	input wire logic capture_compare_pin_i,
	output logic irq_o,
	output logic adc_trig_o
);
	localparam int DIV_W = $clog2(CLOCK_DIV);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CLOCK_DIV - 1);

	logic [2:0] width_config_reg_r;
	logic [1:0] half_mode_field_r [2];
	dhgt_pkg::dhgt_ctl_type timer_control_reg_r;
	logic [31:0] flag_mask_reg_r;
	logic [31:0] raw_flag_reg_r;
	logic [15:0] half_interval_load_r [2];
	logic [7:0] half_prescale_r [2];
	logic [7:0] pre_cnt_r [2];
	logic [15:0] cnt_r [2];
	logic [31:0] half_a_match_reg_r;
	logic [31:0] rdata_r;
	logic adc_trig_r;
	logic [2:0] pin_sync_r;
	logic pin_level_r;
	logic [DIV_W-1:0] div_cnt_r;
	logic clock_tick;

	logic mode32;
	logic mode_timer32;
	logic mode_clock;
	logic mode_half;
	logic [31:0] cnt32;
	logic [31:0] load32;
	logic [1:0] en;
	logic [1:0] frz;
	logic [1:0] run;
	logic [1:0] zero_evt;
	logic clock_run;
	logic clock_match;
	logic [1:0] load_wr;
	logic ctl_wr;
	logic clr_wr;
	logic [1:0] clr_en;
	logic [1:0] adc_en;
	logic [31:0] masked_flag_reg;

	// ------------------------------------------------------------
	// mode decode and run gating
	// ------------------------------------------------------------
	assign mode_timer32 = (width_config_reg_r == dhgt_pkg::CFG_TIMER32);
	assign mode_clock = (width_config_reg_r == dhgt_pkg::CFG_CLOCK32);
	assign mode_half = (width_config_reg_r == dhgt_pkg::CFG_HALF16);
	assign mode32 = mode_timer32 | mode_clock;
	assign cnt32 = {cnt_r[1], cnt_r[0]};
	assign load32 = {half_interval_load_r[1], half_interval_load_r[0]};
	assign en = {timer_control_reg_r.b_en, timer_control_reg_r.a_en};
	assign frz = {timer_control_reg_r.b_freeze, timer_control_reg_r.a_freeze};
	assign adc_en = {timer_control_reg_r.b_adc, timer_control_reg_r.a_adc};
	// freeze only while the processor sits in a debug halt
	assign run = en & ~(frz & {2{dbg_halt_i}});
	// clock mode: either freeze bit stops it, unless the run-through bit is set
	assign clock_run = mode_clock & en[0] & clock_tick &
		~(dbg_halt_i & (|frz) & ~timer_control_reg_r.clock_run);
	assign clock_match = clock_run & (cnt32 == half_a_match_reg_r);
	assign zero_evt[0] = (mode_timer32 & run[0] & (cnt32 == '0)) |
		(mode_half & run[0] & (pre_cnt_r[0] == '0) & (cnt_r[0] == '0));
	assign zero_evt[1] = mode_half & run[1] & (pre_cnt_r[1] == '0) & (cnt_r[1] == '0);

	assign ctl_wr = bus_i.wr & (bus_i.addr == dhgt_pkg::OFF_CONTROL);
	assign clr_wr = bus_i.wr & (bus_i.addr == dhgt_pkg::OFF_FLAG_CLEAR);
	assign load_wr[0] = bus_i.wr & (bus_i.addr == dhgt_pkg::OFF_A_LOAD);
	assign load_wr[1] = bus_i.wr & (bus_i.addr == dhgt_pkg::OFF_B_LOAD);
	// one-shot self-clear of the enable
	assign clr_en[0] = zero_evt[0] & (half_mode_field_r[0] == dhgt_pkg::MODE_ONE_SHOT);
	assign clr_en[1] = zero_evt[1] & (half_mode_field_r[1] == dhgt_pkg::MODE_ONE_SHOT);
	assign masked_flag_reg = raw_flag_reg_r & flag_mask_reg_r;
	assign irq_o = |masked_flag_reg;
	assign rdata_o = rdata_r;
	assign adc_trig_o = adc_trig_r;

	// ------------------------------------------------------------
	// seconds tick from the capture pin
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pin_sync_r <= '0;
		end else begin
			pin_sync_r <= {pin_sync_r[1:0], capture_compare_pin_i};
		end
	end

	// level accepted only once stages two and three agree
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pin_level_r <= 1'b0;
		end else if (pin_sync_r[1] == pin_sync_r[2]) begin
			pin_level_r <= pin_sync_r[2];
		end
	end

	// a rising edge of the accepted level is one 32768 Hz period
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			div_cnt_r <= '0;
		end else if (!mode_clock || !en[0]) begin
			div_cnt_r <= '0;
		end else if (pin_sync_r[1] && pin_sync_r[2] && !pin_level_r) begin
			div_cnt_r <= (div_cnt_r == DIV_LAST) ? '0 : div_cnt_r + 1'b1;
		end
	end
	assign clock_tick = (div_cnt_r == DIV_LAST) &
		pin_sync_r[1] & pin_sync_r[2] & ~pin_level_r;

	// ------------------------------------------------------------
	// configuration and control registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			width_config_reg_r <= '0;
			half_mode_field_r[0] <= '0;
			half_mode_field_r[1] <= '0;
			flag_mask_reg_r <= '0;
			half_a_match_reg_r <= '0;
			half_prescale_r[0] <= dhgt_pkg::PRE_RESET;
			half_prescale_r[1] <= dhgt_pkg::PRE_RESET;
		end else if (bus_i.wr) begin
			case (bus_i.addr)
				dhgt_pkg::OFF_WIDTH_CFG: width_config_reg_r <= bus_i.wdata[2:0];
				dhgt_pkg::OFF_A_MODE: half_mode_field_r[0] <= bus_i.wdata[1:0];
				dhgt_pkg::OFF_B_MODE: half_mode_field_r[1] <= bus_i.wdata[1:0];
				dhgt_pkg::OFF_FLAG_MASK: flag_mask_reg_r <= bus_i.wdata & dhgt_pkg::FLAG_BITS_MASK;
				dhgt_pkg::OFF_A_MATCH: half_a_match_reg_r <= bus_i.wdata;
				dhgt_pkg::OFF_A_PRESCALE: half_prescale_r[0] <= bus_i.wdata[7:0];
				dhgt_pkg::OFF_B_PRESCALE: half_prescale_r[1] <= bus_i.wdata[7:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			timer_control_reg_r <= '0;
		end else if (ctl_wr) begin
			timer_control_reg_r.a_en <= bus_i.wdata[dhgt_pkg::CTL_A_EN];
			timer_control_reg_r.a_freeze <= bus_i.wdata[dhgt_pkg::CTL_A_FREEZE];
			timer_control_reg_r.clock_run <= bus_i.wdata[dhgt_pkg::CTL_CLOCK_RUN];
			timer_control_reg_r.a_adc <= bus_i.wdata[dhgt_pkg::CTL_A_ADC];
			timer_control_reg_r.b_en <= bus_i.wdata[dhgt_pkg::CTL_B_EN];
			timer_control_reg_r.b_freeze <= bus_i.wdata[dhgt_pkg::CTL_B_FREEZE];
			timer_control_reg_r.b_adc <= bus_i.wdata[dhgt_pkg::CTL_B_ADC];
		end else begin
			if (clr_en[0]) begin
				timer_control_reg_r.a_en <= 1'b0;
			end
			if (clr_en[1]) begin
				timer_control_reg_r.b_en <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// interval load registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			half_interval_load_r[0] <= dhgt_pkg::HALF_RESET;
			half_interval_load_r[1] <= dhgt_pkg::HALF_RESET;
		end else if (load_wr[0] && mode32) begin
			half_interval_load_r[0] <= bus_i.wdata[15:0];
			half_interval_load_r[1] <= bus_i.wdata[31:16];
		end else if (load_wr[0]) begin
			half_interval_load_r[0] <= bus_i.wdata[15:0];
		end else if (load_wr[1]) begin
			half_interval_load_r[1] <= bus_i.wdata[15:0];
		end
	end

	// ------------------------------------------------------------
	// counters
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_r[0] <= dhgt_pkg::HALF_RESET;
			cnt_r[1] <= dhgt_pkg::HALF_RESET;
			pre_cnt_r[0] <= dhgt_pkg::PRE_RESET;
			pre_cnt_r[1] <= dhgt_pkg::PRE_RESET;
		end else if (bus_i.wr && bus_i.addr == dhgt_pkg::OFF_WIDTH_CFG &&
			bus_i.wdata[2:0] == dhgt_pkg::CFG_CLOCK32 && !mode_clock) begin
			{cnt_r[1], cnt_r[0]} <= dhgt_pkg::CLOCK_START;
		end else if (mode_timer32) begin
			if (load_wr[0] && en[0]) begin
				{cnt_r[1], cnt_r[0]} <= bus_i.wdata;
			end else if (zero_evt[0]) begin
				{cnt_r[1], cnt_r[0]} <= load32;
			end else if (run[0]) begin
				{cnt_r[1], cnt_r[0]} <= cnt32 - 32'h0000_0001;
			end
		end else if (mode_clock) begin
			if (clock_match) begin
				{cnt_r[1], cnt_r[0]} <= dhgt_pkg::CLOCK_ROLL;
			end else if (clock_run) begin
				{cnt_r[1], cnt_r[0]} <= cnt32 + 32'h0000_0001;
			end
		end else if (mode_half) begin
			for (int i = 0; i < 2; i++) begin
				if (load_wr[i] && en[i]) begin
					cnt_r[i] <= bus_i.wdata[15:0];
					pre_cnt_r[i] <= half_prescale_r[i];
				end else if (zero_evt[i]) begin
					cnt_r[i] <= half_interval_load_r[i];
					pre_cnt_r[i] <= half_prescale_r[i];
				end else if (run[i] && pre_cnt_r[i] != '0) begin
					pre_cnt_r[i] <= pre_cnt_r[i] - 8'h01;
				end else if (run[i]) begin
					cnt_r[i] <= cnt_r[i] - 16'h0001;
					pre_cnt_r[i] <= half_prescale_r[i];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// flags and trigger; a same-cycle event beats the clear
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			raw_flag_reg_r <= '0;
		end else begin
			raw_flag_reg_r[dhgt_pkg::FLG_A_TIMEOUT] <= zero_evt[0] |
				(raw_flag_reg_r[dhgt_pkg::FLG_A_TIMEOUT] &
				~(clr_wr & bus_i.wdata[dhgt_pkg::FLG_A_TIMEOUT]));
			raw_flag_reg_r[dhgt_pkg::FLG_B_TIMEOUT] <= zero_evt[1] |
				(raw_flag_reg_r[dhgt_pkg::FLG_B_TIMEOUT] &
				~(clr_wr & bus_i.wdata[dhgt_pkg::FLG_B_TIMEOUT]));
			raw_flag_reg_r[dhgt_pkg::FLG_CLOCK_MATCH] <= clock_match |
				(raw_flag_reg_r[dhgt_pkg::FLG_CLOCK_MATCH] &
				~(clr_wr & bus_i.wdata[dhgt_pkg::FLG_CLOCK_MATCH]));
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			adc_trig_r <= 1'b0;
		end else begin
			adc_trig_r <= |(zero_evt & adc_en);
		end
	end

	// ------------------------------------------------------------
	// read port: data in the cycle after the strobe, zero elsewhere
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_r <= '0;
		end else if (!bus_i.rd) begin
			rdata_r <= '0;
		end else begin
			case (bus_i.addr)
				dhgt_pkg::OFF_WIDTH_CFG: rdata_r <= {29'h0, width_config_reg_r};
				dhgt_pkg::OFF_A_MODE: rdata_r <= {30'h0, half_mode_field_r[0]};
				dhgt_pkg::OFF_B_MODE: rdata_r <= {30'h0, half_mode_field_r[1]};
				dhgt_pkg::OFF_CONTROL: rdata_r <= {18'h0, timer_control_reg_r.b_adc, 3'h0,
					timer_control_reg_r.b_freeze, timer_control_reg_r.b_en, 2'h0,
					timer_control_reg_r.a_adc, timer_control_reg_r.clock_run, 2'h0,
					timer_control_reg_r.a_freeze, timer_control_reg_r.a_en};
				dhgt_pkg::OFF_FLAG_MASK: rdata_r <= flag_mask_reg_r;
				dhgt_pkg::OFF_RAW_FLAG: rdata_r <= raw_flag_reg_r;
				dhgt_pkg::OFF_MASKED_FLAG: rdata_r <= masked_flag_reg;
				dhgt_pkg::OFF_A_LOAD: rdata_r <= mode32 ? load32 : {16'h0, half_interval_load_r[0]};
				dhgt_pkg::OFF_B_LOAD: rdata_r <= {16'h0, half_interval_load_r[1]};
				dhgt_pkg::OFF_A_MATCH: rdata_r <= half_a_match_reg_r;
				dhgt_pkg::OFF_A_PRESCALE: rdata_r <= {24'h0, half_prescale_r[0]};
				dhgt_pkg::OFF_B_PRESCALE: rdata_r <= {24'h0, half_prescale_r[1]};
				dhgt_pkg::OFF_A_COUNT: rdata_r <= mode32 ? cnt32 : {16'h0, cnt_r[0]};
				dhgt_pkg::OFF_B_COUNT: rdata_r <= {16'h0, cnt_r[1]};
				default: rdata_r <= '0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);

	sequence s_hit_zero32;
		mode_timer32 && zero_evt[0] && !bus_i.wr;
	endsequence
	sequence s_reload32;
		cnt32 == $past(load32);
	endsequence

	a_reload_thirtytwo: assert property (s_hit_zero32 |=> s_reload32)
		else $error("32-bit counter did not reload after zero");
	a_oneshot_stop: assert property (
		(s_hit_zero32 and half_mode_field_r[0] == dhgt_pkg::MODE_ONE_SHOT)
		|=> !timer_control_reg_r.a_en)
		else $error("one-shot did not clear its enable");
	a_timeout_flag: assert property (
		zero_evt[0] |=> raw_flag_reg_r[dhgt_pkg::FLG_A_TIMEOUT])
		else $error("timeout flag not set");
	a_timeout_hold: assert property (
		raw_flag_reg_r[dhgt_pkg::FLG_A_TIMEOUT] &&
		!(clr_wr && bus_i.wdata[dhgt_pkg::FLG_A_TIMEOUT])
		|=> raw_flag_reg_r[dhgt_pkg::FLG_A_TIMEOUT])
		else $error("timeout flag not held");
	a_adc_gate: assert property (
		adc_trig_o |-> $past(|(zero_evt & adc_en)))
		else $error("ADC trigger without enabled timeout");
	a_load_rewrite: assert property (
		mode_timer32 && load_wr[0] && en[0] |=> cnt32 == $past(bus_i.wdata))
		else $error("load rewrite not taken next clock");
	a_halt_freeze: assert property (
		mode_timer32 && dbg_halt_i && frz[0] && !bus_i.wr |=> $stable(cnt32))
		else $error("count moved during debug halt");
	a_clock_roll: assert property (
		clock_match && !bus_i.wr
		|=> cnt32 == dhgt_pkg::CLOCK_ROLL && raw_flag_reg_r[dhgt_pkg::FLG_CLOCK_MATCH])
		else $error("clock did not roll over and flag");
	a_prescale_hold: assert property (
		mode_half && run[0] && pre_cnt_r[0] != '0 && !bus_i.wr
		|=> $stable(cnt_r[0]) && pre_cnt_r[0] == $past(pre_cnt_r[0]) - 8'h01)
		else $error("prescaler did not hold the count");
	a_read_concat: assert property (
		bus_i.rd && bus_i.addr == dhgt_pkg::OFF_A_COUNT && mode32
		|=> rdata_o == $past(cnt32))
		else $error("32-bit count read mismatch");
endmodule

// file: dv/dhgt_timer_bench.sv
// dhgt_timer_bench: self-checking bench for the dual half timer
`timescale 1ns/1ps
module dhgt_timer_bench;
	localparam int DIV = 4;
	logic core_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	dhgt_pkg::dhgt_bus_type bus = '0;
	logic [31:0] rdata;
	logic dbg_halt = 1'b0;
	logic pin = 1'b0;
	logic pin_run = 1'b0;
	logic [1:0] pin_div = 2'h0;
	logic irq;
	logic adc;
	int mismatches = 0;
	int n_checks = 0;
	int adc_cnt = 0;
	int rises = 0;

	dhgt_timer #(.CLOCK_DIV(DIV)) u_dhgt_timer (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.bus_i(bus),
		.rdata_o(rdata),
		.dbg_halt_i(dbg_halt),
		.capture_compare_pin_i(pin),
		.irq_o(irq),
		.adc_trig_o(adc)
	);

	always #2.5 core_clk_i = ~core_clk_i;

	// --------------------------------------------------------
	// seconds-clock source: pin period of eight core cycles
	// --------------------------------------------------------
	always @(posedge core_clk_i) begin
		pin_div <= pin_div + 2'h1;
		if (pin_run && pin_div == 2'h3) begin
			pin <= ~pin;
			if (!pin) begin
				rises <= rises + 1;
			end
		end
		if (adc === 1'b1) begin
			adc_cnt <= adc_cnt + 1;
		end
	end

	// --------------------------------------------------------
	// helpers
	// --------------------------------------------------------
	task automatic results();
		if (mismatches == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge core_clk_i);
		bus.wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk_i);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge core_clk_i);
		bus.rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	// bounded wait; cycles counted from the edge that took the last write
	task automatic wait_adc(input int limit, output logic [31:0] cyc);
		cyc = '0;
		while (cyc < limit) begin
			@(posedge core_clk_i);
			#1;
			cyc++;
			if (adc === 1'b1) break;
		end
		if (adc !== 1'b1) begin
			chk("adc pulse wait", 32'h1, {31'h0, adc});
			results();
		end
	endtask

	task automatic poll_raw(input int b, input int limit);
		logic [31:0] v;
		int i;
		v = '0;
		for (i = 0; i < limit; i++) begin
			rd(dhgt_pkg::OFF_RAW_FLAG, v);
			if (v[b] === 1'b1) break;
		end
		if (v[b] !== 1'b1) begin
			chk("raw flag wait", 32'h1, {31'h0, v[b]});
			results();
		end
	endtask

	// --------------------------------------------------------
	// main sequence
	// --------------------------------------------------------
	initial begin
		logic [31:0] v;
		logic [31:0] u;
		logic [31:0] w;
		logic [31:0] ld;
		logic [31:0] cyc;
		int p;
		int r0;
		void'($urandom(45555));
		repeat (4) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		rd(dhgt_pkg::OFF_A_LOAD, v);
		chk("load reset", 32'hFFFF_FFFF, v);
		rd(dhgt_pkg::OFF_A_COUNT, v);
		chk("count reset", 32'hFFFF_FFFF, v);
		rd(dhgt_pkg::OFF_CONTROL, v);
		chk("control reset", 32'h0, v);
		rd(dhgt_pkg::OFF_A_PRESCALE, v);
		chk("a prescale reset", 32'h0, v);
		rd(dhgt_pkg::OFF_B_PRESCALE, v);
		chk("b prescale reset", 32'h0, v);
		rd(8'h7C, v);
		chk("unmapped read", 32'h0, v);
		@(posedge core_clk_i);
		#1;
		chk("rdata idle", 32'h0, rdata);
		// 32-bit one-shot; half b mode set periodic to show it is ignored
		ld = 32'h8 + ($urandom % 24);
		wr(dhgt_pkg::OFF_A_MODE, 32'h1);
		wr(dhgt_pkg::OFF_B_MODE, 32'h2);
		wr(dhgt_pkg::OFF_FLAG_MASK, 32'h1);
		wr(dhgt_pkg::OFF_CONTROL, 32'h21);
		wr(dhgt_pkg::OFF_A_LOAD, ld);
		wait_adc(200, cyc);
		chk("one-shot cycles", ld + 32'h1, cyc);
		@(posedge core_clk_i);
		#1;
		chk("adc width", 32'h0, {31'h0, adc});
		rd(dhgt_pkg::OFF_CONTROL, v);
		chk("one-shot enable", 32'h0, {31'h0, v[0]});
		rd(dhgt_pkg::OFF_A_COUNT, v);
		chk("one-shot reload", ld, v);
		rd(dhgt_pkg::OFF_MASKED_FLAG, v);
		chk("masked timeout", 32'h1, v);
		chk("irq set", 32'h1, {31'h0, irq});
		wr(dhgt_pkg::OFF_FLAG_CLEAR, 32'h1);
		rd(dhgt_pkg::OFF_RAW_FLAG, v);
		chk("raw cleared", 32'h0, v & dhgt_pkg::FLAG_BITS_MASK);
		chk("irq cleared", 32'h0, {31'h0, irq});
		// periodic, masked, no trigger, load rewritten while running
		wr(dhgt_pkg::OFF_FLAG_MASK, 32'h0);
		wr(dhgt_pkg::OFF_A_MODE, 32'h2);
		wr(dhgt_pkg::OFF_B_MODE, 32'h1);
		wr(dhgt_pkg::OFF_CONTROL, 32'h1);
		wr(dhgt_pkg::OFF_A_LOAD, 32'h0010_0000);
		p = adc_cnt;
		wr(dhgt_pkg::OFF_A_LOAD, 32'h6 + ($urandom % 8));
		poll_raw(0, 12);
		wr(dhgt_pkg::OFF_FLAG_CLEAR, 32'h1);
		poll_raw(0, 12);
		rd(dhgt_pkg::OFF_CONTROL, v);
		chk("periodic enable", 32'h1, {31'h0, v[0]});
		chk("no trigger", 32'(p), 32'(adc_cnt));
		rd(dhgt_pkg::OFF_MASKED_FLAG, v);
		chk("masked off", 32'h0, v);
		chk("irq masked", 32'h0, {31'h0, irq});
		// debug freeze and word ordering; upper half kept large so half b
		// cannot time out from this stale count once 16-bit mode starts
		w = {16'h0040 + 16'($urandom % 4), 16'h0100};
		wr(dhgt_pkg::OFF_CONTROL, 32'h3);
		wr(dhgt_pkg::OFF_A_LOAD, w);
		rd(dhgt_pkg::OFF_B_LOAD, v);
		chk("b load upper", {16'h0, w[31:16]}, v);
		@(posedge core_clk_i);
		dbg_halt <= 1'b1;
		rd(dhgt_pkg::OFF_A_COUNT, v);
		repeat (10) @(posedge core_clk_i);
		rd(dhgt_pkg::OFF_A_COUNT, u);
		chk("frozen count", v, u);
		chk("count upper", {16'h0, w[31:16]}, {16'h0, v[31:16]});
		@(posedge core_clk_i);
		dbg_halt <= 1'b0;
		rd(dhgt_pkg::OFF_A_COUNT, u);
		chk("resumed", 32'h1, {31'h0, u < v});
		// two 16-bit halves
		wr(dhgt_pkg::OFF_CONTROL, 32'h0);
		wr(dhgt_pkg::OFF_FLAG_CLEAR, dhgt_pkg::FLAG_BITS_MASK);
		wr(dhgt_pkg::OFF_WIDTH_CFG, 32'h4);
		p = $urandom % 4;
		wr(dhgt_pkg::OFF_A_MODE, 32'h2);
		wr(dhgt_pkg::OFF_B_MODE, 32'h1);
		wr(dhgt_pkg::OFF_A_PRESCALE, 32'(p));
		wr(dhgt_pkg::OFF_FLAG_MASK, 32'h100);
		wr(dhgt_pkg::OFF_CONTROL, 32'h2101);
		wr(dhgt_pkg::OFF_A_LOAD, 32'h0003_8000);
		ld = 32'h8 + ($urandom % 24);
		wr(dhgt_pkg::OFF_B_LOAD, ld);
		wait_adc(200, cyc);
		chk("half b cycles", ld + 32'h1, cyc);
		rd(dhgt_pkg::OFF_CONTROL, v);
		chk("half enables", 32'h1, v & 32'h101);
		rd(dhgt_pkg::OFF_RAW_FLAG, v);
		chk("half b raw", 32'h100, v & dhgt_pkg::FLAG_BITS_MASK);
		chk("half b irq", 32'h1, {31'h0, irq});
		rd(dhgt_pkg::OFF_A_COUNT, v);
		repeat (8 * (p + 1) - 2) @(posedge core_clk_i);
		rd(dhgt_pkg::OFF_A_COUNT, u);
		chk("prescaled drop", 32'h8, v - u);
		chk("half a upper", 32'h0, {16'h0, v[31:16]});
		chk("half a untouched", 32'h1, {31'h0, v > 32'h7000});
		wr(dhgt_pkg::OFF_CONTROL, 32'h0);
		wr(dhgt_pkg::OFF_FLAG_CLEAR, dhgt_pkg::FLAG_BITS_MASK);
		// seconds clock kept running through a frozen debug halt
		wr(dhgt_pkg::OFF_WIDTH_CFG, 32'h1);
		rd(dhgt_pkg::OFF_A_COUNT, v);
		chk("clock start", dhgt_pkg::CLOCK_START, v);
		wr(dhgt_pkg::OFF_A_MATCH, 32'h2);
		wr(dhgt_pkg::OFF_FLAG_MASK, 32'h8);
		@(posedge core_clk_i);
		dbg_halt <= 1'b1;
		wr(dhgt_pkg::OFF_CONTROL, 32'h13);
		r0 = rises;
		@(posedge core_clk_i);
		pin_run <= 1'b1;
		poll_raw(3, 80);
		chk("pin rises", 32'h1, {31'h0, (rises - r0) inside {2 * DIV, 2 * DIV + 1}});
		rd(dhgt_pkg::OFF_A_COUNT, v);
		chk("clock rolled", dhgt_pkg::CLOCK_ROLL, v);
		rd(dhgt_pkg::OFF_MASKED_FLAG, v);
		chk("clock masked", 32'h8, v);
		chk("clock irq", 32'h1, {31'h0, irq});
		wr(dhgt_pkg::OFF_FLAG_CLEAR, 32'h8);
		rd(dhgt_pkg::OFF_RAW_FLAG, v);
		chk("clock cleared", 32'h0, v & dhgt_pkg::FLAG_BITS_MASK);
		chk("clock irq off", 32'h0, {31'h0, irq});
		results();
	end
endmodule
